// file: rtl/occ_pkg.sv
package occ_pkg;
    // =========================================================
    // frequency table, units of 0.1 mhz
    localparam int OCC_IDX_W = 5;
    localparam int OCC_STEP_W = 11;
    localparam int OCC_ACC_W = 12;
    localparam int OCC_NUM_FREQ = 17;
    localparam logic [OCC_STEP_W-1:0] OCC_FREQ_TABLE [OCC_NUM_FREQ] = '{
        11'h019, 11'h01F, 11'h02B, 11'h036, 11'h045, 11'h051, 11'h05C, 11'h064, 11'h082,
        11'h096, 11'h0C8, 11'h104, 11'h140, 11'h190, 11'h21C, 11'h320, 11'h65E};
    // =========================================================
    // defaults and limits
    localparam logic [OCC_IDX_W-1:0] OCC_OSC_DEFAULT_IDX = 5'h00;
    localparam logic [OCC_IDX_W-1:0] OCC_CMC_DEFAULT_IDX = 5'h01;
    localparam logic [OCC_IDX_W-1:0] OCC_CMC_MAX_IDX = 5'h0E;
    localparam logic [OCC_IDX_W-1:0] OCC_MAX_IDX = 5'h10;
    // accumulator modulus equals the top frequency, so 163 mhz is one tick per cycle
    localparam logic [OCC_ACC_W-1:0] OCC_MODULUS = 12'h65E;

    function automatic logic [OCC_STEP_W-1:0] occ_freq_of(input logic [OCC_IDX_W-1:0] idx);
        logic [OCC_STEP_W-1:0] f;
        f = OCC_FREQ_TABLE[0];
        if (idx <= OCC_MAX_IDX)
        begin
            f = OCC_FREQ_TABLE[idx];
        end
        return f;
    endfunction : occ_freq_of
endpackage : occ_pkg

// file: rtl/occ_osc_if.sv
`timescale 1ns/1ps
interface occ_osc_if;
    import occ_pkg::*;
    logic [OCC_STEP_W-1:0] req_step;
    logic tick;
    logic [OCC_STEP_W-1:0] applied_step;
    modport ctrl (output req_step, input tick, input applied_step);
    modport gen (input req_step, output tick, output applied_step);
endinterface : occ_osc_if

// file: rtl/occ_phase_gen.sv
`timescale 1ns/1ps
module occ_phase_gen
    import occ_pkg::*;
#(
    parameter logic [OCC_STEP_W-1:0] RESET_STEP = 11'h019
)
(
    input wire logic clock,
    input wire logic rst_n,
    occ_osc_if.gen osc
);
    typedef struct packed {
        logic [OCC_ACC_W-1:0] acc;
        logic [OCC_STEP_W-1:0] step;
        logic tick;
    } occ_gen_s;

    occ_gen_s r;
    occ_gen_s next_r;
    logic [OCC_ACC_W-1:0] sum;

    // =========================================================
    // phase accumulator, one tick per oscillator period
    always_comb
    begin
        next_r = r;
        sum = r.acc + {1'b0, r.step};
        next_r.tick = 1'b0;
        if (sum >= OCC_MODULUS)
        begin
            next_r.acc = sum - OCC_MODULUS;
            next_r.tick = 1'b1;
            // new rate only at a period boundary: no runt periods
            next_r.step = osc.req_step;
        end
        else
        begin
            next_r.acc = sum;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r <= '{acc: '0, step: RESET_STEP, tick: 1'b0};
        end
        else
        begin
            r <= next_r;
        end
    end

    assign osc.tick = r.tick;
    assign osc.applied_step = r.step;
endmodule : occ_phase_gen

// file: rtl/occ_top.sv
// Operation
// - configuration master clock comes from an internal oscillator model and paces configuration.
// - oscillator and master clock run always, also after configuration ends.
// - after power-up the master clock runs at its default rate until reselected.
// - a new master clock rate applies only after clock configuration bits arrive.
// - rates are a fixed table of seventeen discrete settings, nothing between.
// - oscillator defaults to the lowest table entry, 2.5 mhz.
// - master clock defaults to the second table entry, 3.1 mhz.
// - oscillator output can be routed onto the user clock tree.
`timescale 1ns/1ps
module occ_top
    import occ_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic reconfig_start,
    input wire logic clock_bits_valid,
    input wire logic [OCC_IDX_W-1:0] cmc_sel,
    input wire logic config_done,
    input wire logic [OCC_IDX_W-1:0] osc_user_sel,
    input wire logic osc_route_en,
    output logic config_master_clock,
    output logic config_master_clock_tick,
    output logic osc_tick,
    output logic user_clock_tick,
    output logic clock_bits_taken,
    output logic sel_rejected,
    output logic [OCC_IDX_W-1:0] cmc_idx,
    output logic [OCC_IDX_W-1:0] osc_idx
);
    typedef struct packed {
        logic [OCC_IDX_W-1:0] cmc_idx;
        logic [OCC_IDX_W-1:0] osc_idx;
        logic bits_taken;
        logic rejected;
        logic cmc_level;
        logic cmc_tick;
        logic osc_tick;
        logic user_tick;
    } occ_top_s;

    occ_top_s r;
    occ_top_s next_r;

    occ_osc_if osc_bus ();
    occ_osc_if cmc_bus ();

    // =========================================================
    // oscillator and master clock generators
    occ_phase_gen #(
        .RESET_STEP(OCC_FREQ_TABLE[OCC_OSC_DEFAULT_IDX])
    ) u_osc (
        .clock(clock),
        .rst_n(rst_n),
        .osc(osc_bus.gen)
    );

    occ_phase_gen #(
        .RESET_STEP(OCC_FREQ_TABLE[OCC_CMC_DEFAULT_IDX])
    ) u_cmc (
        .clock(clock),
        .rst_n(rst_n),
        .osc(cmc_bus.gen)
    );

    // rates come only from the table, an out-of-range index falls back to entry 0 in the lookup
    assign osc_bus.req_step = occ_freq_of(r.osc_idx);
    assign cmc_bus.req_step = occ_freq_of(r.cmc_idx);

    // =========================================================
    // selection control
    always_comb
    begin
        next_r = r;
        next_r.rejected = 1'b0;
        if (reconfig_start)
        begin
            // back to defaults for the next configuration pass
            next_r.cmc_idx = OCC_CMC_DEFAULT_IDX;
            next_r.osc_idx = OCC_OSC_DEFAULT_IDX;
            next_r.bits_taken = 1'b0;
        end
        else if (clock_bits_valid && !r.bits_taken)
        begin
            next_r.bits_taken = 1'b1;
            // top settings invalid for the master clock: keep the default
            if (cmc_sel <= OCC_CMC_MAX_IDX)
            begin
                next_r.cmc_idx = cmc_sel;
            end
            else
            begin
                next_r.rejected = 1'b1;
            end
        end
        else if (config_done && r.bits_taken && osc_user_sel <= OCC_MAX_IDX)
        begin
            // user mode may use any entry, top two included
            next_r.osc_idx = osc_user_sel;
        end
        // both generators free-run in every phase
        next_r.osc_tick = osc_bus.tick;
        next_r.cmc_tick = cmc_bus.tick;
        next_r.cmc_level = cmc_bus.tick ? ~r.cmc_level : r.cmc_level;
        next_r.user_tick = osc_bus.tick & osc_route_en & config_done;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r <= '{cmc_idx: OCC_CMC_DEFAULT_IDX, osc_idx: OCC_OSC_DEFAULT_IDX, default: '0};
        end
        else
        begin
            r <= next_r;
        end
    end

    assign config_master_clock = r.cmc_level;
    assign config_master_clock_tick = r.cmc_tick;
    assign osc_tick = r.osc_tick;
    assign user_clock_tick = r.user_tick;
    assign clock_bits_taken = r.bits_taken;
    assign sel_rejected = r.rejected;
    assign cmc_idx = r.cmc_idx;
    assign osc_idx = r.osc_idx;
endmodule : occ_top

// file: verif/occ_chk.sv
`timescale 1ns/1ps
module occ_chk
    import occ_pkg::*;
(
    input wire logic clock, rst_n, reconfig_start, clock_bits_valid, config_done, osc_route_en,
    input wire logic [OCC_IDX_W-1:0] cmc_sel, osc_user_sel, cmc_idx, osc_idx,
    input wire logic config_master_clock, config_master_clock_tick, osc_tick, user_clock_tick,
    input wire logic clock_bits_taken, sel_rejected
);
    // ====
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_take;
        clock_bits_valid && !clock_bits_taken && !reconfig_start;
    endsequence
    a_take_applies: assert property (s_take ##0 cmc_sel <= 5'h0E |=> cmc_idx == $past(cmc_sel) && clock_bits_taken)
        else $error("select not applied");
    a_refuse_top: assert property (s_take ##0 cmc_sel > 5'h0E |=> sel_rejected && cmc_idx == OCC_CMC_DEFAULT_IDX)
        else $error("top setting not refused");
    a_restart_default: assert property (reconfig_start |=> cmc_idx == 5'h01 && osc_idx == 5'h00 && !clock_bits_taken)
        else $error("defaults not restored");
    a_idx_holds: assert property (clock_bits_taken && !reconfig_start |=> $stable(cmc_idx))
        else $error("index moved");
    a_reject_pulse: assert property (sel_rejected |=> !sel_rejected)
        else $error("reject too long");
    a_route_gate: assert property (user_clock_tick |-> $past(osc_route_en && config_done))
        else $error("ungated user tick");
    a_master_runs: assert property (config_master_clock_tick |=> ##[0:70] config_master_clock_tick)
        else $error("master clock stopped");
    a_osc_runs: assert property (osc_tick |=> ##[0:70] osc_tick)
        else $error("oscillator stopped");
    a_idx_legal: assert property (cmc_idx <= OCC_CMC_MAX_IDX && osc_idx <= OCC_MAX_IDX)
        else $error("index out of table");
    a_level_follows: assert property ($changed(config_master_clock) == config_master_clock_tick)
        else $error("master clock level not toggled by tick");
endmodule : occ_chk
bind occ_top occ_chk occ_chk_inst (.clock, .rst_n, .reconfig_start, .clock_bits_valid, .config_done, .osc_route_en,
    .cmc_sel, .osc_user_sel, .cmc_idx, .osc_idx, .config_master_clock, .config_master_clock_tick, .osc_tick,
    .user_clock_tick, .clock_bits_taken, .sel_rejected);

// file: verif/occ_tree_model.sv
`timescale 1ns/1ps
// ====
// clock tree consumer, counts ticks; clr restarts a window
module occ_tree_model
(
    input wire logic clock,
    input wire logic clr,
    input wire logic cmc_tick,
    input wire logic user_tick,
    output int cmc_count,
    output int user_count
);
    always @(posedge clock)
    begin
        cmc_count <= clr ? 0 : cmc_count + int'(cmc_tick);
        user_count <= clr ? 0 : user_count + int'(user_tick);
    end
endmodule : occ_tree_model

// file: verif/test_config_oscillator_clock_select.sv
`timescale 1ns/1ps
module test_config_oscillator_clock_select;
    import occ_pkg::*;
    logic clock = 0, rst_n = 0, reconfig_start = 0, clock_bits_valid = 0, config_done = 0, osc_route_en = 0, clr = 1;
    logic [OCC_IDX_W-1:0] cmc_sel = 0, osc_user_sel = 0, cmc_idx, osc_idx;
    logic config_master_clock, config_master_clock_tick, osc_tick, user_clock_tick, clock_bits_taken, sel_rejected;
    int cmc_count, user_count, c, u, num_errors = 0, n_tests = 0;
    occ_top occ_top_inst (.clock, .rst_n, .reconfig_start, .clock_bits_valid, .cmc_sel, .config_done, .osc_user_sel,
        .osc_route_en, .config_master_clock, .config_master_clock_tick, .osc_tick, .user_clock_tick,
        .clock_bits_taken, .sel_rejected, .cmc_idx, .osc_idx);
    occ_tree_model occ_tree_model_inst (.clock, .clr, .cmc_tick(config_master_clock_tick),
        .user_tick(user_clock_tick), .cmc_count, .user_count);
    initial forever #50 clock = ~clock;
    // ====
    // helpers; a window of 1630 cycles holds exactly one tick per 0.1 mhz
    task automatic chk(input logic ok);
        n_tests++;
        if (ok !== 1'b1)
        begin
            num_errors++;
            $display("mismatch at %0t: wrong value", $time);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc
    task automatic window;
        clr = 1; cyc(1); clr = 0; cyc(1630); c = cmc_count; u = user_count;
    endtask : window
    task automatic take(input logic [OCC_IDX_W-1:0] s);
        clock_bits_valid = 1; cmc_sel = s; cyc(1); clock_bits_valid = 0;
    endtask : take
    task automatic restart;
        reconfig_start = 1; cyc(1); reconfig_start = 0; cyc(1);
    endtask : restart
    // ====
    // scenarios
    task automatic t_defaults;
        chk(cmc_idx === OCC_CMC_DEFAULT_IDX && clock_bits_taken === 1'b0);
        chk(osc_idx === OCC_OSC_DEFAULT_IDX);
        cyc(200); window;
        chk(c === int'(OCC_FREQ_TABLE[1]) && u === 0);
    endtask : t_defaults
    task automatic t_select;
        take(5'h0E);
        chk(cmc_idx === 5'h0E && clock_bits_taken === 1'b1);
        cyc(1); take(5'h03); cyc(1);
        chk(cmc_idx === 5'h0E);
        cyc(100); window;
        chk(c === int'(OCC_FREQ_TABLE[14]));
    endtask : t_select
    task automatic t_refuse;
        for (int s = 15; s < 17; s++)
        begin
            restart;
            take(s[OCC_IDX_W-1:0]);
            chk(sel_rejected === 1'b1 && cmc_idx === OCC_CMC_DEFAULT_IDX);
            cyc(1);
        end
    endtask : t_refuse
    task automatic t_user;
        config_done = 1; osc_route_en = 1; osc_user_sel = 5'h10; cyc(200);
        chk(osc_idx === 5'h10);
        window;
        chk(u === int'(OCC_FREQ_TABLE[16]) && c === int'(OCC_FREQ_TABLE[1]));
        osc_route_en = 0; cyc(2); window;
        chk(u === 0);
    endtask : t_user
    task automatic conclude;
        if (num_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude
    initial
    begin
        cyc(6); rst_n = 1; cyc(2);
        t_defaults; t_select; t_refuse; t_user;
        conclude;
    end
    initial
    begin
        #2000000; num_errors++; conclude;
    end
endmodule : test_config_oscillator_clock_select
